/* File: rtl/ges_pkg.sv */
// Purpose: constants for the guest event-blocking state and entry-check block
// Assumes: register indices are word indices on a plain strobe port
// Notes: register offsets, blocking and held-debug bit positions, and the blocking, held-debug and chain reset values live here
//
// Overview of operation
// - stack segment load blocks interrupts one instruction, flagged in blocking bit 1
// - stack segment load also inhibits some debug exceptions; bit 1 covers both
// - system management interrupts stay blocked in system mode, flagged by bit 2
// - nmi or system interrupt delivery blocks further nmis until interrupt return; bit 3
// - clear bit 3 alone does not unblock nmis; other holds still apply
// - vm entry fails when any blocking-state bit 31:4 is set
// - held debug events kept in a 64-bit field, 32 without wide mode
// - bits 3:0 flag breakpoints met, even when not enabled
// - bit 12 set when an enabled data or io breakpoint was met
// - bit 14 set when single step would have trapped
// - vm entry fails on held-debug bit 13, 11:4 or 63:15 set
// - held-debug bits 63:32 exist only in wide mode
// - every vm exit loads processor state from the host fields
// - host set holds control, page base, feature, stack and instruction pointers
// - host set holds seven 16-bit selectors, none for local table
// - host set holds fs, gs, task and two table base addresses
// - every vm exit also loads fixed-value components with no host field
// - set-interrupt-flag with flag clear blocks one instruction, flagged in bit 0
package ges_pkg;
    // register word indices
    localparam logic [4:0] REG_BLOCK = 5'h00;
    localparam logic [4:0] REG_DEBUG = 5'h01;
    localparam logic [4:0] REG_CHAIN = 5'h02;
    localparam logic [4:0] REG_STATUS = 5'h03;
    localparam logic [4:0] REG_HOST_BASE = 5'h08;
    // host field count and layout (entry number from REG_HOST_BASE)
    localparam int HOST_COUNT = 17;
    localparam int FIXED_COUNT = 2;
    localparam int HOST_SEL_FIRST = 5;
    localparam int HOST_SEL_LAST = 11;
    // blocking-state bits
    localparam int BLK_SET_IF = 0;
    localparam int BLK_STACK_LOAD = 1;
    localparam int BLK_SYS_INT = 2;
    localparam int BLK_NMI = 3;
    localparam logic [31:0] BLK_RSVD_MASK = 32'hFFFF_FFF0;
    // held-debug bits
    localparam int DBG_ENABLED_BP = 12;
    localparam int DBG_SINGLE_STEP = 14;
    localparam logic [63:0] DBG_RSVD_MASK = 64'hFFFF_FFFF_FFFF_AFF0;
    localparam logic [63:0] NARROW_MASK = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] SEL_MASK = 64'h0000_0000_0000_FFFF;
    // reset values
    localparam logic [31:0] BLK_RESET = 32'h0000_0000;
    localparam logic [63:0] DBG_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CHAIN_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] CHAIN_ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
    // sequencer states
    typedef enum logic [1:0] {
        GES_IDLE,
        GES_CHECK,
        GES_EXIT_LOAD
    } ges_state_e;
endpackage : ges_pkg

/* File: rtl/ges_vm_guest_event_state_check.sv */
// Purpose: guest event-blocking state, held debug events, entry check, host load
// Assumes: all core strobes are on core_clk_in and last one cycle
// Notes: host state leaves as a stream of index/data words, one per cycle
`timescale 1ns/1ps
module ges_vm_guest_event_state_check
    import ges_pkg::*;
#(
    parameter bit WIDE_MODE = 1'b1,
    parameter logic [63:0] FIXED_VALUE = 64'h0000_0000_0000_0000,
    parameter int ADDR_W = 5
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [63:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [63:0] reg_rdata_out,
    // instruction and event strobes from the pipeline
    input wire logic instr_retire_in,
    input wire logic stack_segment_load_in,
    input wire logic set_interrupt_flag_instr_in,
    input wire logic interrupt_enable_flag_in,
    input wire logic nmi_delivered_in,
    input wire logic system_mgmt_interrupt_in,
    input wire logic system_mgmt_mode_in,
    input wire logic interrupt_return_instr_in,
    input wire logic nmi_other_hold_in,
    // debug event sources
    input wire logic [3:0] breakpoint_met_in,
    input wire logic [3:0] debug_control_register_en_in,
    input wire logic [3:0] breakpoint_data_io_in,
    input wire logic single_step_pending_in,
    input wire logic debug_delivered_in,
    // vm transitions
    input wire logic vm_entry_req_in,
    input wire logic vm_exit_req_in,
    // blocking status to the core
    output logic interrupts_blocked_out,
    output logic debug_inhibit_out,
    output logic sys_int_blocked_out,
    output logic nmi_blocked_out,
    // entry result
    output logic entry_done_out,
    output logic entry_fail_out,
    // host state load stream
    output logic host_load_valid_out,
    output logic [4:0] host_load_index_out,
    output logic [63:0] host_load_data_out,
    output logic exit_done_out
);

    // refuse widths the decoder cannot serve
    generate
        if (ADDR_W < 5) begin : g_bad_addr
            $error("ADDR_W must be at least 5");
        end
    endgenerate

    localparam int LOAD_LAST = HOST_COUNT + FIXED_COUNT - 1;

    logic [31:0] blocking_state;
    logic [31:0] next_blocking_state;
    logic [63:0] held_debug;
    logic [63:0] next_held_debug;
    logic [63:0] chain_pointer;
    logic [63:0] host_mem [0:HOST_COUNT-1];
    logic [63:0] width_mask;
    logic entry_violation;
    logic last_fail;
    logic [4:0] load_count;
    ges_state_e state;
    logic wr_block;
    logic wr_debug;
    logic enabled_bp_hit;
    logic [4:0] host_entry;
    logic host_hit;

    // narrow parts drop the upper word of held-debug, host and fixed-value fields; the chain pointer keeps all 64 bits
    assign width_mask = WIDE_MODE ? CHAIN_ALL_ONES : NARROW_MASK;

    // decode of the register port
    assign wr_block = reg_wr_in && (reg_addr_in == ADDR_W'(REG_BLOCK));
    assign wr_debug = reg_wr_in && (reg_addr_in == ADDR_W'(REG_DEBUG));
    assign host_entry = 5'(reg_addr_in - ADDR_W'(REG_HOST_BASE));
    assign host_hit = (reg_addr_in >= ADDR_W'(REG_HOST_BASE))
        && (reg_addr_in < ADDR_W'(int'(REG_HOST_BASE) + HOST_COUNT));

    // blocking-state next value: software write, then clears, then sets;
    // sets go last so an event landing with a clear is never lost
    always_comb begin
        next_blocking_state = blocking_state;
        if (wr_block) begin
            next_blocking_state = reg_wdata_in[31:0];
        end
        // one-instruction blocks end when the following instruction retires
        if (instr_retire_in) begin
            next_blocking_state[BLK_SET_IF] = 1'b0;
            next_blocking_state[BLK_STACK_LOAD] = 1'b0;
        end
        if (!system_mgmt_mode_in) begin
            next_blocking_state[BLK_SYS_INT] = 1'b0;
        end
        if (interrupt_return_instr_in) begin
            next_blocking_state[BLK_NMI] = 1'b0;
        end
        if (set_interrupt_flag_instr_in && !interrupt_enable_flag_in) begin
            next_blocking_state[BLK_SET_IF] = 1'b1;
        end
        if (stack_segment_load_in) begin
            next_blocking_state[BLK_STACK_LOAD] = 1'b1;
        end
        if (system_mgmt_mode_in) begin
            next_blocking_state[BLK_SYS_INT] = 1'b1;
        end
        if (nmi_delivered_in || system_mgmt_interrupt_in) begin
            next_blocking_state[BLK_NMI] = 1'b1;
        end
    end

    // blocking-state register
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            blocking_state <= BLK_RESET;
        end else begin
            blocking_state <= next_blocking_state;
        end
    end

    // status to the core follows the next value so it lines up with the field
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            interrupts_blocked_out <= 1'b0;
            debug_inhibit_out <= 1'b0;
            sys_int_blocked_out <= 1'b0;
            nmi_blocked_out <= 1'b0;
        end else begin
            interrupts_blocked_out <= next_blocking_state[BLK_SET_IF]
                || next_blocking_state[BLK_STACK_LOAD];
            debug_inhibit_out <= next_blocking_state[BLK_STACK_LOAD];
            sys_int_blocked_out <= next_blocking_state[BLK_SYS_INT];
            // other hold reasons keep nmis off even with bit 3 clear
            nmi_blocked_out <= next_blocking_state[BLK_NMI]
                || nmi_other_hold_in;
        end
    end

    // an enabled data or io breakpoint counts toward the summary bit
    assign enabled_bp_hit = |(breakpoint_met_in & debug_control_register_en_in
        & breakpoint_data_io_in);

    // held-debug next value; delivery clears, new recognitions win over it
    always_comb begin
        next_held_debug = held_debug;
        if (wr_debug) begin
            next_held_debug = reg_wdata_in;
        end
        if (debug_delivered_in) begin
            next_held_debug[3:0] = 4'h0;
            next_held_debug[DBG_ENABLED_BP] = 1'b0;
            next_held_debug[DBG_SINGLE_STEP] = 1'b0;
        end
        // raw hit flags ignore the enables on purpose
        next_held_debug[3:0] = next_held_debug[3:0] | breakpoint_met_in;
        if (enabled_bp_hit) begin
            next_held_debug[DBG_ENABLED_BP] = 1'b1;
        end
        if (single_step_pending_in) begin
            next_held_debug[DBG_SINGLE_STEP] = 1'b1;
        end
        next_held_debug = next_held_debug & width_mask;
    end

    // held-debug register
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            held_debug <= DBG_RESET;
        end else begin
            held_debug <= next_held_debug;
        end
    end

    // chain pointer is storage only; software should keep it all ones
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            chain_pointer <= CHAIN_RESET;
        end else if (reg_wr_in && (reg_addr_in == ADDR_W'(REG_CHAIN))) begin
            chain_pointer <= reg_wdata_in;
        end
    end

    // host field storage: selectors keep 16 bits, the rest follow the mode
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < HOST_COUNT; i++) begin
                host_mem[i] <= 64'h0000_0000_0000_0000;
            end
        end else if (reg_wr_in && host_hit) begin
            if ((int'(host_entry) >= HOST_SEL_FIRST)
                && (int'(host_entry) <= HOST_SEL_LAST)) begin
                host_mem[host_entry] <= reg_wdata_in & SEL_MASK;
            end else begin
                host_mem[host_entry] <= reg_wdata_in & width_mask;
            end
        end
    end

    // every reserved bit of either field feeds one failure flag
    assign entry_violation = (|(blocking_state & BLK_RSVD_MASK))
        || (|(held_debug & DBG_RSVD_MASK));

    // sequencer: entry check takes one cycle, exit streams host fields
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            state <= GES_IDLE;
            load_count <= 5'h00;
        end else begin
            case (state)
                GES_IDLE: begin
                    load_count <= 5'h00;
                    // an exit seen in idle is never dropped, so it outranks an entry
                    if (vm_exit_req_in) begin
                        state <= GES_EXIT_LOAD;
                    end else if (vm_entry_req_in) begin
                        state <= GES_CHECK;
                    end
                end
                GES_CHECK: begin
                    state <= GES_IDLE;
                end
                GES_EXIT_LOAD: begin
                    if (int'(load_count) == LOAD_LAST) begin
                        state <= GES_IDLE;
                        load_count <= 5'h00;
                    end else begin
                        load_count <= 5'(load_count + 5'h01);
                    end
                end
                default: begin
                    state <= GES_IDLE;
                    load_count <= 5'h00;
                end
            endcase
        end
    end

    // entry verdict, sampled in the single check cycle
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            entry_done_out <= 1'b0;
            entry_fail_out <= 1'b0;
            last_fail <= 1'b0;
        end else begin
            entry_done_out <= (state == GES_CHECK);
            if (state == GES_CHECK) begin
                entry_fail_out <= entry_violation;
                last_fail <= entry_violation;
            end else begin
                entry_fail_out <= 1'b0;
            end
        end
    end

    // host load stream: stored fields first, then fixed-value components
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            host_load_valid_out <= 1'b0;
            host_load_index_out <= 5'h00;
            host_load_data_out <= 64'h0000_0000_0000_0000;
            exit_done_out <= 1'b0;
        end else begin
            host_load_valid_out <= (state == GES_EXIT_LOAD);
            host_load_index_out <= load_count;
            exit_done_out <= (state == GES_EXIT_LOAD)
                && (int'(load_count) == LOAD_LAST);
            if (state != GES_EXIT_LOAD) begin
                host_load_data_out <= 64'h0000_0000_0000_0000;
            end else if (int'(load_count) < HOST_COUNT) begin
                host_load_data_out <= host_mem[load_count];
            end else begin
                host_load_data_out <= FIXED_VALUE & width_mask;
            end
        end
    end

    // read port: data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 64'h0000_0000_0000_0000;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= 64'h0000_0000_0000_0000;
        end else if (host_hit) begin
            reg_rdata_out <= host_mem[host_entry];
        end else begin
            case (5'(reg_addr_in))
                REG_BLOCK: begin
                    reg_rdata_out <= {32'h0000_0000, blocking_state};
                end
                REG_DEBUG: begin
                    reg_rdata_out <= held_debug;
                end
                REG_CHAIN: begin
                    reg_rdata_out <= chain_pointer;
                end
                REG_STATUS: begin
                    // live check result, last verdict, pointer sanity, busy
                    reg_rdata_out <= {60'h0, (state != GES_IDLE),
                        (chain_pointer == CHAIN_ALL_ONES), last_fail,
                        entry_violation};
                end
                default: begin
                    reg_rdata_out <= 64'h0000_0000_0000_0000;
                end
            endcase
        end
    end

endmodule : ges_vm_guest_event_state_check

/* File: testbench/ges_check_sva.sv */
// Purpose: port-level checks of blocking outputs, entry verdict and host stream
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to every instance of the top module by the bind below
`timescale 1ns/1ps
module ges_check_sva (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // watched inputs
    input wire logic reg_rd_in,
    input wire logic instr_retire_in,
    input wire logic stack_segment_load_in,
    input wire logic nmi_delivered_in,
    input wire logic system_mgmt_interrupt_in,
    input wire logic system_mgmt_mode_in,
    input wire logic interrupt_return_instr_in,
    input wire logic nmi_other_hold_in,
    input wire logic vm_entry_req_in,
    // watched outputs
    input wire logic [63:0] reg_rdata_out,
    input wire logic interrupts_blocked_out,
    input wire logic debug_inhibit_out,
    input wire logic sys_int_blocked_out,
    input wire logic nmi_blocked_out,
    input wire logic entry_done_out,
    input wire logic entry_fail_out,
    input wire logic host_load_valid_out,
    input wire logic [4:0] host_load_index_out,
    input wire logic exit_done_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // a host stream opens on word 0 and must close on word 18 without a gap
    sequence exit_open_s;
        $rose(host_load_valid_out) && host_load_index_out == 5'h00;
    endsequence
    sequence exit_close_s;
        host_load_valid_out throughout (##18 (exit_done_out && host_load_index_out == 5'h12));
    endsequence
    ss_block_set_a: assert property (stack_segment_load_in |=> interrupts_blocked_out && debug_inhibit_out) else $error("stack load did not block");
    retire_clear_a: assert property (instr_retire_in && !stack_segment_load_in |=> !debug_inhibit_out) else $error("stack load block outlived one instruction");
    sys_int_follow_a: assert property (1'b1 |=> sys_int_blocked_out == $past(system_mgmt_mode_in)) else $error("system interrupt block not tracking system mode");
    nmi_set_a: assert property (nmi_delivered_in || system_mgmt_interrupt_in |=> nmi_blocked_out) else $error("delivery did not block nmi");
    nmi_clear_a: assert property (interrupt_return_instr_in && !nmi_delivered_in && !system_mgmt_interrupt_in && !nmi_other_hold_in |=> !nmi_blocked_out) else $error("return did not unblock nmi");
    nmi_hold_a: assert property (nmi_other_hold_in |=> nmi_blocked_out) else $error("other hold did not block nmi");
    entry_timing_a: assert property (entry_done_out |-> $past(vm_entry_req_in, 2)) else $error("entry verdict at wrong time");
    fail_qual_a: assert property (entry_fail_out |-> entry_done_out) else $error("fail flag outside verdict");
    read_slot_a: assert property (reg_rdata_out != 64'h0 |-> $past(reg_rd_in)) else $error("read data outside its slot");
    exit_stream_a: assert property (exit_open_s |-> exit_close_s) else $error("host stream broken");
endmodule : ges_check_sva

bind ges_vm_guest_event_state_check ges_check_sva i_sva (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_rd_in(reg_rd_in),
    .instr_retire_in(instr_retire_in), .stack_segment_load_in(stack_segment_load_in),
    .nmi_delivered_in(nmi_delivered_in), .system_mgmt_interrupt_in(system_mgmt_interrupt_in),
    .system_mgmt_mode_in(system_mgmt_mode_in), .nmi_other_hold_in(nmi_other_hold_in),
    .interrupt_return_instr_in(interrupt_return_instr_in), .vm_entry_req_in(vm_entry_req_in),
    .reg_rdata_out(reg_rdata_out), .interrupts_blocked_out(interrupts_blocked_out),
    .debug_inhibit_out(debug_inhibit_out), .sys_int_blocked_out(sys_int_blocked_out),
    .nmi_blocked_out(nmi_blocked_out), .entry_done_out(entry_done_out),
    .entry_fail_out(entry_fail_out), .host_load_valid_out(host_load_valid_out),
    .host_load_index_out(host_load_index_out), .exit_done_out(exit_done_out)
);

/* File: testbench/vm_guest_event_state_check_tb_top.sv */
// Purpose: self-checking bench for event blocking, held debug, entry check, host load
// Assumes: all pipeline strobes are one-cycle pulses launched at a rising edge
// Notes: levels ride in lv: 0 flag, 1 system mode, 2 other hold, 6:3 enables, 10:7 data/io
`timescale 1ns/1ps
module vm_guest_event_state_check_tb_top
    import ges_pkg::*;
;
    localparam logic [63:0] FIXED_TB = 64'h0000_0000_5A5A_0F0F;
    localparam logic [9:0] RET = 10'h001, SSL = 10'h002, SIF = 10'h004, NMI = 10'h008;
    localparam logic [9:0] SMG = 10'h010, IRT = 10'h020, STP = 10'h040, DLV = 10'h080;
    localparam logic [9:0] ENT = 10'h100, EXT = 10'h200;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [63:0] wdata = 64'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] ev = 10'h000;
    logic [3:0] bp = 4'h0;
    logic [10:0] lv = 11'h000;
    logic [63:0] rdata, hdata, d;
    logic ib, di, sb, nb, ed, ef, hv, xd, fail;
    logic [4:0] hidx;
    logic [31:0] r, b;
    logic [63:0] host [17];
    logic [31:0] seed = 32'hFDB6;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    ges_vm_guest_event_state_check #(.WIDE_MODE(1'b1), .FIXED_VALUE(FIXED_TB), .ADDR_W(5)) i_dut (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .instr_retire_in(ev[0]),
        .stack_segment_load_in(ev[1]), .set_interrupt_flag_instr_in(ev[2]),
        .interrupt_enable_flag_in(lv[0]), .nmi_delivered_in(ev[3]),
        .system_mgmt_interrupt_in(ev[4]), .system_mgmt_mode_in(lv[1]),
        .interrupt_return_instr_in(ev[5]), .nmi_other_hold_in(lv[2]),
        .breakpoint_met_in(bp), .debug_control_register_en_in(lv[6:3]),
        .breakpoint_data_io_in(lv[10:7]), .single_step_pending_in(ev[6]),
        .debug_delivered_in(ev[7]), .vm_entry_req_in(ev[8]), .vm_exit_req_in(ev[9]),
        .interrupts_blocked_out(ib), .debug_inhibit_out(di), .sys_int_blocked_out(sb),
        .nmi_blocked_out(nb), .entry_done_out(ed), .entry_fail_out(ef),
        .host_load_valid_out(hv), .host_load_index_out(hidx), .host_load_data_out(hdata),
        .exit_done_out(xd)
    );
    // free-running core clock, 20 ns period
    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end
    // hang guard: far above the few hundred cycles the sequence needs
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [4:0] a, input logic [63:0] v);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [4:0] a, input logic [63:0] e);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk
    // one-cycle strobes; levels are left standing for later steps
    task automatic pulse(input logic [9:0] m, input logic [3:0] p, input logic [10:0] l);
        @(posedge core_clk_in);
        ev <= m;
        bp <= p;
        lv <= l;
        @(posedge core_clk_in);
        ev <= 10'h000;
        bp <= 4'h0;
        #1;
    endtask : pulse
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        rd_chk(REG_BLOCK, 64'h0);
        rd_chk(REG_DEBUG, 64'h0);
        rd_chk(REG_CHAIN, {64{1'b1}});
        rd_chk(REG_STATUS, 64'h4);
        rd_chk(5'h1F, 64'h0);
        pulse(SSL, 4'h0, 11'h000);
        chk({ib, di}, 2'b11);
        rd_chk(REG_BLOCK, 64'h2);
        pulse(RET, 4'h0, 11'h000);
        chk({ib, di}, 2'b00);
        pulse(SIF, 4'h0, 11'h000);
        chk(ib, 1'b1);
        rd_chk(REG_BLOCK, 64'h1);
        pulse(RET, 4'h0, 11'h001);
        pulse(SIF, 4'h0, 11'h001);
        chk(ib, 1'b0);
        pulse(10'h000, 4'h0, 11'h002);
        chk(sb, 1'b1);
        rd_chk(REG_BLOCK, 64'h4);
        pulse(NMI, 4'h0, 11'h000);
        chk({sb, nb}, 2'b01);
        pulse(IRT, 4'h0, 11'h000);
        chk(nb, 1'b0);
        pulse(SMG, 4'h0, 11'h000);
        chk(nb, 1'b1);
        pulse(IRT, 4'h0, 11'h004);
        chk(nb, 1'b1);
        pulse(10'h000, 4'h0, 11'h000);
        chk(nb, 1'b0);
        pulse(10'h000, 4'hF, 11'h000);
        rd_chk(REG_DEBUG, 64'hF);
        pulse(DLV, 4'h0, 11'h000);
        pulse(STP, 4'h1, 11'h0F8);
        rd_chk(REG_DEBUG, 64'h5001);
        pulse(DLV, 4'h2, 11'h008);
        rd_chk(REG_DEBUG, 64'h2);
        // one clean case, one per reserved range, one with every legal bit set except blocking bit 2
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            b = 32'h0;
            d = 64'h0;
            case (i)
                1: b = 32'h10 << (r % 28);
                2: d = 64'h2000;
                3: d = 64'h10 << (r % 8);
                4: d = 64'h8000 << (r % 49);
                5: begin
                    b = 32'hB;
                    d = 64'h500F;
                end
                default: d = 64'h0;
            endcase
            fail = (b[31:4] != 28'h0) || (d[11:4] != 8'h0) || d[13] || (d[63:15] != 49'h0);
            wr_reg(REG_BLOCK, {32'h0, b});
            wr_reg(REG_DEBUG, d);
            rd_chk(REG_DEBUG, d);
            pulse(ENT, 4'h0, 11'h000);
            for (int k = 0; k < 6 && ed !== 1'b1; k++) begin
                @(posedge core_clk_in);
                #1;
            end
            chk({ed, ef}, {1'b1, fail});
            rd_chk(REG_STATUS, {60'h0, 2'b01, fail, fail});
        end
        for (int i = 0; i < 17; i++) begin
            host[i] = {$random(seed), $random(seed)};
            wr_reg(REG_HOST_BASE + i[4:0], host[i]);
            if (i >= 5 && i <= 11) host[i] = host[i] & 64'hFFFF;
        end
        wr_reg(REG_STATUS, 64'h0);
        rd_chk(REG_STATUS, 64'h4);
        pulse(EXT, 4'h0, 11'h000);
        for (int k = 0; k < 6 && hv !== 1'b1; k++) begin
            @(posedge core_clk_in);
            #1;
        end
        for (int i = 0; i < 19; i++) begin
            chk({hv, xd, hidx, hdata}, {1'b1, i == 18, i[4:0], (i < 17) ? host[i] : FIXED_TB});
            @(posedge core_clk_in);
            #1;
        end
        chk(hv, 1'b0);
        wrap_up();
    end
endmodule : vm_guest_event_state_check_tb_top
